/* File: tb.sv */
// bench of the usb event flag block: apb access plus far-side model
// assumes a 200 MHz pclk and a shortened idle count
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import uef_pkg::*;
   localparam logic [11:0] AF = OFF_EVENT_FLAGS;
   localparam logic [11:0] AE = OFF_EVENT_ENABLES;
   localparam logic [11:0] AR = OFF_ERROR_FLAGS;
   localparam logic [11:0] AN = OFF_ERROR_ENABLES;
   localparam logic [11:0] AS = OFF_XFER_STATUS;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic hoe = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, tok_rdy, irq, dp, dm;
   wire logic [7:0] ev, err;
   wire logic [5:0] st;
   int n_fail = 0;
   int total_checks = 0;

   always #2.5 pclk = ~pclk;

   uef_sie_model sie (.pclk(pclk), .token_ready(tok_rdy), .ev(ev),
      .err(err), .st(st), .dp(dp), .dm(dm));

   uef_event_flags #(.IDLE_CYCLES(50)) dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .host_operation_enable(hoe),
      .line_dp(dp), .line_dm(dm), .stall_rx_event(ev[7]),
      .stall_tx_event(ev[6]), .token_done_event(ev[5]),
      .token_status(st), .token_ready(tok_rdy), .sof_rx_event(ev[4]),
      .sof_threshold_event(ev[3]), .bus_reset_event(ev[2]),
      .eop_event(ev[1]), .packet_start_event(ev[0]),
      .error_events(err), .module_interrupt_request(irq));

   ////////////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         n_fail++;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] x,
           input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q & m, x);
   endtask

   task ir(input logic x);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, {31'h0, x});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic e;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(AF, 32'h0);
      rd(AE, 32'h0);
      rd(AR, 32'h0);
      repeat (60) @(posedge pclk);
      rd(AF, 32'h10);
      wr(AF, 32'hFF);
      rd(AF, 32'h0);
      wr(AE, 32'hFFFFFFFF);
      rd(AE, 32'hFF);
      wr(AE, 32'h0);
      // device mode
      sie.fire(8'h80, 8'h00, 6'h00);
      rd(AF, 32'h0);
      sie.fire(8'h40, 8'h00, 6'h00);
      rd(AF, 32'h80);
      sie.fire(8'h18, 8'h00, 6'h00);
      rd(AF, 32'h84);
      sie.fire(8'h04, 8'h00, 6'h00);
      rd(AF, 32'h85);
      wr(AF, 32'h0);
      rd(AF, 32'h85);
      wr(AF, 32'h04);
      rd(AF, 32'h81);
      ir(1'b0);
      wr(AE, 32'h80);
      ir(1'b1);
      wr(AF, 32'h80);
      ir(1'b0);
      wr(AE, 32'h01);
      ir(1'b1);
      wr(AF, 32'hFF);
      wr(AE, 32'h0);
      // two tokens queued
      sie.fire(8'h20, 8'h00, 6'h2B);
      sie.fire(8'h20, 8'h00, 6'h15);
      rd(AF, 32'h08);
      rd(AS, 32'hAC);
      wr(AF, 32'h08);
      rd(AF, 32'h08);
      rd(AS, 32'h54);
      wr(AF, 32'h08);
      rd(AF, 32'h0);
      // fill the status fifo, the fifth token is refused
      for (int i = 1; i <= 5; i++) begin
         sie.fire(8'h20, 8'h00, 6'(i));
      end
      @(posedge pclk);
      chk({31'h0, tok_rdy}, 32'h0);
      for (int i = 1; i <= 4; i++) begin
         rd(AS, 32'(i << STAT_SHIFT));
         wr(AF, 32'h08);
      end
      rd(AF, 32'h0);
      chk({31'h0, tok_rdy}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         sie.fire(8'h00, 8'h01 << i, 6'h00);
         rd(AR, 32'h1 << i);
         rd(AF, 32'h0);
         wr(AR, 32'h1 << i);
         rd(AR, 32'h0);
      end
      wr(AN, 32'h04);
      sie.fire(8'h00, 8'h04, 6'h00);
      rd(AF, 32'h02);
      ir(1'b0);
      wr(AE, 32'h02);
      ir(1'b1);
      wr(AF, 32'h02);
      rd(AF, 32'h02);
      wr(AR, 32'hFF);
      rd(AF, 32'h0);
      ir(1'b0);
      wr(AE, 32'h0);
      wr(AN, 32'h0);
      // turnaround: cancelled, then expired
      sie.fire(8'h02, 8'h00, 6'h00);
      sie.fire(8'h01, 8'h00, 6'h00);
      repeat (300) @(posedge pclk);
      rd(AR, 32'h0);
      sie.fire(8'h02, 8'h00, 6'h00);
      repeat (255) @(posedge pclk);
      rd(AR, 32'h0);
      repeat (40) @(posedge pclk);
      rd(AR, 32'h10);
      wr(AR, 32'hFF);
      // resume enabled only around suspend
      wr(AE, 32'h20);
      sie.line(LINE_K);
      repeat (495) @(posedge pclk);
      rd(AF, 32'h0);
      repeat (15) @(posedge pclk);
      rd(AF, 32'h20);
      ir(1'b1);
      wr(AE, 32'h0);
      sie.line(LINE_J);
      repeat (60) @(posedge pclk);
      rd(AF, 32'h30);
      wr(AF, 32'hFF);
      // host mode
      hoe <= 1'b1;
      sie.line(LINE_SE0);
      repeat (20) @(posedge pclk);
      sie.line(LINE_J);
      repeat (520) @(posedge pclk);
      rd(AF, 32'h40, 32'h40);
      wr(AF, 32'hFF);
      sie.fire(8'h80, 8'h00, 6'h00);
      sie.fire(8'h40, 8'h00, 6'h00);
      sie.fire(8'h0C, 8'h00, 6'h00);
      rd(AF, 32'h84, 32'hAF);
      sie.line(LINE_SE0);
      repeat (520) @(posedge pclk);
      rd(AF, 32'h01, 32'h01);
      // reset in mid-run clears flags and enables
      wr(AE, 32'h81);
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(AF, 32'h0);
      rd(AE, 32'h0);
      ir(1'b0);
      // a write without byte lane 0 is refused
      pstrb <= 4'hE;
      wr(AE, 32'hFF);
      pstrb <= 4'hF;
      rd(AE, 32'h0);
      apb(1'b0, 12'h020, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      print_verdict;
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      print_verdict;
   end
endmodule

/* File: uef_event_flags.sv */
// usb event flags, error flags, enables and module interrupt over apb
// assumes sie event inputs are one-cycle pulses on pclk; dp/dm are pins
module uef_event_flags #(
   parameter int IDLE_CYCLES = uef_pkg::IDLE_CYC
) (
   input wire logic pclk, // system clock, 200 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   input wire logic host_operation_enable, // host mode when high
   input wire logic line_dp, // d+ pin level
   input wire logic line_dm, // d- pin level
   input wire logic stall_rx_event, // stall handshake received
   input wire logic stall_tx_event, // stall handshake sent
   input wire logic token_done_event, // token processing finished
   input wire logic [uef_pkg::STAT_W-1:0] token_status, // endpoint info
   output logic token_ready, // status fifo has room
   input wire logic sof_rx_event, // sof token received
   input wire logic sof_threshold_event, // host sof threshold reached
   input wire logic bus_reset_event, // valid usb reset seen
   input wire logic eop_event, // end of packet, reply awaited
   input wire logic packet_start_event, // reply packet begins
   input wire logic [7:0] error_events, // sie error pulses by bit
   output logic module_interrupt_request // module interrupt
);
   import uef_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0] sync1;
      logic [1:0] line;
      logic [1:0] line_d;
      logic attached;
      logic [7:0] ev;
      logic [7:0] ev_en;
      logic [7:0] err;
      logic [7:0] err_en;
      logic turn_run;
      logic [TURN_W-1:0] turn_cnt;
      logic [31:0] rdata;
      logic irq;
   } uef_state_type;
   uef_state_type st_r, st_nxt;
   // line pins idle at j, so the synchroniser starts there
   localparam uef_state_type ST_RESET = '{sync1: LINE_J, line: LINE_J,
      line_d: LINE_J, default: '0};

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   function automatic int hold_of(input int i);
      hold_of = (i == 1) ? IDLE_CYCLES : HOLD_CYC;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // line timers: 0 resume, 1 idle, 2 attach, 3 detach
   logic [3:0] tcond;
   logic [3:0] tdone;
   logic host;
   logic se0;
   logic line_quiet;

   assign host = host_operation_enable;
   assign se0 = (st_r.line == LINE_SE0);
   assign line_quiet = (st_r.line == st_r.line_d);
   assign tcond[0] = (st_r.line == LINE_K);
   assign tcond[1] = (st_r.line == LINE_J);
   assign tcond[2] = host && !st_r.attached && !se0 && line_quiet;
   assign tcond[3] = host && st_r.attached && se0;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_tmr
         uef_line_timer #(.CYC(hold_of(gi))) u_tmr (
            .pclk(pclk),
            .presetn(presetn),
            .cond(tcond[gi]),
            .done(tdone[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // transfer status fifo
   logic [STAT_W-1:0] stat_head;
   logic [STAT_AW:0] stat_count;
   logic stat_push;
   logic stat_pop;

   assign token_ready = (stat_count != (STAT_AW + 1)'(STAT_DEPTH));
   assign stat_push = token_done_event && token_ready;

   uef_stat_fifo u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .push(stat_push),
      .push_data(token_status),
      .pop(stat_pop),
      .head(stat_head),
      .count(stat_count)
   );

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   logic mapped;
   logic wr;
   logic [7:0] clr_ev;
   logic [7:0] clr_err;
   logic [7:0] ev_set;
   logic [7:0] err_set;
   logic summary;
   logic [7:0] ev_view;

   assign mapped = hit(paddr, OFF_EVENT_FLAGS) ||
      hit(paddr, OFF_EVENT_ENABLES) || hit(paddr, OFF_ERROR_FLAGS) ||
      hit(paddr, OFF_ERROR_ENABLES) || hit(paddr, OFF_XFER_STATUS);
   assign wr = psel && penable && pwrite && pstrb[0] && mapped;
   assign clr_ev = (wr && hit(paddr, OFF_EVENT_FLAGS)) ?
      pwdata[REG_BITS-1:0] : 8'h00;
   assign clr_err = (wr && hit(paddr, OFF_ERROR_FLAGS)) ?
      pwdata[REG_BITS-1:0] : 8'h00;
   assign stat_pop = clr_ev[BIT_TOKEN_DONE] && st_r.ev[BIT_TOKEN_DONE];
   assign summary = |(st_r.err & st_r.err_en);
   always_comb begin
      ev_view = st_r.ev;
      ev_view[BIT_SUMMARY_ERR] = summary;
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   ////////////////////////////////////////////////////////////////////////
   // hardware set sources
   always_comb begin
      ev_set = 8'h00;
      ev_set[BIT_STALL] = host ? stall_rx_event : stall_tx_event;
      ev_set[BIT_ATTACH] = tdone[2];
      ev_set[BIT_RESUME] = tdone[0];
      ev_set[BIT_IDLE] = tdone[1];
      ev_set[BIT_TOKEN_DONE] = stat_push;
      ev_set[BIT_FRAME_START] = host ? sof_threshold_event :
         sof_rx_event;
      ev_set[BIT_RESET_DETACH] = host ? tdone[3] :
         bus_reset_event;
      // bits 7 to 0 from the sie, bit 4 also set by the turnaround timer
      // bit 1 is crc5 in device mode, eof in host mode
      // bit 0 is pid check failure
      err_set = error_events;
      err_set[BIT_TURNAROUND] = error_events[BIT_TURNAROUND] ||
         (st_r.turn_run && st_r.turn_cnt == TURN_W'(TURN_CYC - 1));
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync1 = {line_dp, line_dm};
      st_nxt.line = st_r.sync1;
      st_nxt.line_d = st_r.line;
      if (tdone[2]) begin
         st_nxt.attached = 1'b1;
      end else if (tdone[3] || !host) begin
         st_nxt.attached = 1'b0;
      end
      // set wins over a simultaneous clear
      st_nxt.ev = (st_r.ev & ~clr_ev) | ev_set;
      st_nxt.ev[BIT_SUMMARY_ERR] = 1'b0;
      if (stat_pop && stat_count > (STAT_AW + 1)'(1)) begin
         st_nxt.ev[BIT_TOKEN_DONE] = 1'b1;
      end
      st_nxt.err = (st_r.err & ~clr_err) | err_set;
      if (wr && hit(paddr, OFF_EVENT_ENABLES)) begin
         st_nxt.ev_en = pwdata[REG_BITS-1:0];
      end
      if (wr && hit(paddr, OFF_ERROR_ENABLES)) begin
         st_nxt.err_en = pwdata[REG_BITS-1:0];
      end
      // turnaround: count idle after eop until a reply starts
      if (packet_start_event || !(st_r.line == LINE_J)) begin
         st_nxt.turn_run = 1'b0;
         st_nxt.turn_cnt = '0;
      end else if (eop_event) begin
         st_nxt.turn_run = 1'b1;
         st_nxt.turn_cnt = '0;
      end else if (st_r.turn_run) begin
         if (st_r.turn_cnt == TURN_W'(TURN_CYC - 1)) begin
            st_nxt.turn_run = 1'b0;
         end else begin
            st_nxt.turn_cnt = st_r.turn_cnt + TURN_W'(1);
         end
      end
      // read data captured in the setup phase
      if (psel && !penable && !pwrite) begin
         st_nxt.rdata = 32'h0000_0000;
         case (paddr)
            OFF_EVENT_FLAGS: st_nxt.rdata[REG_BITS-1:0] = ev_view;
            OFF_EVENT_ENABLES: st_nxt.rdata[REG_BITS-1:0] = st_r.ev_en;
            OFF_ERROR_FLAGS: st_nxt.rdata[REG_BITS-1:0] = st_r.err;
            OFF_ERROR_ENABLES: st_nxt.rdata[REG_BITS-1:0] = st_r.err_en;
            OFF_XFER_STATUS: begin
               st_nxt.rdata[REG_BITS-1:0] =
                  {stat_head, {STAT_SHIFT{1'b0}}};
            end
            default: st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // error summary reaches the request only through its enable
      st_nxt.irq = |(ev_view & st_r.ev_en);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign module_interrupt_request = st_r.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_token_pop;
      stat_pop && !stat_push && stat_count == (STAT_AW + 1)'(1);
   endsequence

   stall_host_a: assert property (host && stall_rx_event |=>
      st_r.ev[BIT_STALL]) else $error("host stall not flagged");
   stall_dev_a: assert property (!host && stall_tx_event |=>
      st_r.ev[BIT_STALL]) else $error("device stall not flagged");
   frame_host_a: assert property (host && sof_threshold_event |=>
      st_r.ev[BIT_FRAME_START]) else $error("sof threshold not flagged");
   reset_dev_a: assert property (!host && bus_reset_event |=>
      st_r.ev[BIT_RESET_DETACH]) else $error("bus reset not flagged");
   flag_hold_a: assert property (st_r.ev[BIT_STALL] &&
      !clr_ev[BIT_STALL] |=> st_r.ev[BIT_STALL])
      else $error("stall flag lost without clear");
   flag_clear_a: assert property (clr_err[BIT_TURNAROUND] &&
      !err_set[BIT_TURNAROUND] |=> !st_r.err[BIT_TURNAROUND])
      else $error("error flag not cleared by one");
   token_drain_a: assert property (s_token_pop |=>
      !st_r.ev[BIT_TOKEN_DONE] && stat_count == '0)
      else $error("token pop did not empty fifo");
   stuff_err_a: assert property (error_events[7] |=>
      st_r.err[7]) else $error("bit stuff error not flagged");
   turn_time_a: assert property (eop_event && !packet_start_event &&
      st_r.line == LINE_J ##1 (st_r.line == LINE_J && !packet_start_event &&
      !eop_event)[*8] |-> !st_r.err[BIT_TURNAROUND] ||
      $past(st_r.err[BIT_TURNAROUND], 9))
      else $error("turnaround flagged too early");
   summary_mask_a: assert property (st_r.err_en == 8'h00 &&
      psel && !penable && !pwrite && paddr == OFF_EVENT_FLAGS |=>
      !prdata[BIT_SUMMARY_ERR]) else $error("masked error in summary");
   upper_zero_a: assert property (prdata[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   irq_match_a: assert property (##1 module_interrupt_request ==
      $past(|(st_r.ev & st_r.ev_en) ||
      (|(st_r.err & st_r.err_en) && st_r.ev_en[BIT_SUMMARY_ERR])))
      else $error("interrupt mismatch");
   err_gate_a: assert property (!st_r.ev_en[BIT_SUMMARY_ERR] &&
      ((st_r.ev & st_r.ev_en) == 8'h00) |=> !module_interrupt_request)
      else $error("error interrupt without enable");

   ////////////////////////////////////////////////////////////////////////
   // flags follow their sources, and a full fifo refuses tokens
   frame_dev_a: assert property (!host && sof_rx_event |=>
      st_r.ev[BIT_FRAME_START]) else $error("sof not flagged");
   token_set_a: assert property (token_done_event && token_ready |=>
      st_r.ev[BIT_TOKEN_DONE]) else $error("token done not flagged");
   token_drop_a: assert property (token_done_event && !token_ready &&
      !stat_pop |=> stat_count == $past(stat_count))
      else $error("token taken while fifo full");

   // line timer outcomes, looked at where the flag rises
   resume_k_a: assert property ($rose(st_r.ev[BIT_RESUME]) |->
      $past(st_r.line == LINE_K, 2)) else $error("resume without k state");
   idle_j_a: assert property ($rose(st_r.ev[BIT_IDLE]) |->
      $past(st_r.line == LINE_J, 2)) else $error("idle without j state");
   attach_line_a: assert property ($rose(st_r.ev[BIT_ATTACH]) |->
      $past(host && !se0 && line_quiet && !st_r.attached, 2))
      else $error("attach outside quiet host bus");
   detach_se0_a: assert property ($past(host) &&
      $rose(st_r.ev[BIT_RESET_DETACH]) |-> $past(host && se0 &&
      st_r.attached, 2)) else $error("detach without se0 hold");

   // register access and the summary path
   enable_write_a: assert property (psel && penable && pwrite &&
      pstrb[0] && paddr == OFF_EVENT_ENABLES |=>
      st_r.ev_en == $past(pwdata[REG_BITS-1:0]))
      else $error("enable write lost");
   summary_set_a: assert property (|(st_r.err & st_r.err_en) &&
      psel && !penable && !pwrite && paddr == OFF_EVENT_FLAGS |=>
      prdata[BIT_SUMMARY_ERR]) else $error("enabled error not summed");
   err_irq_a: assert property (|(st_r.err & st_r.err_en) &&
      st_r.ev_en[BIT_SUMMARY_ERR] |=> module_interrupt_request)
      else $error("enabled error without interrupt");

   // per-bit error set and sticky event flags
   generate
      for (gi = 0; gi < 8; gi++) begin : g_chk
         err_set_a: assert property (error_events[gi] |=>
            st_r.err[gi]) else $error("error event not flagged");
         if (gi != BIT_SUMMARY_ERR) begin : g_ev
            ev_keep_a: assert property (st_r.ev[gi] && !clr_ev[gi] |=>
               st_r.ev[gi]) else $error("event flag lost without clear");
         end
      end
   endgenerate
endmodule

/* File: uef_line_timer.sv */
// line condition timer: one pulse once a level has held for CYC cycles
// assumes cond is already synchronous to pclk
module uef_line_timer #(
   parameter int CYC = 500
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic cond, // level being timed
   output logic done // one-cycle pulse when held
);
   import uef_pkg::*;
   typedef struct packed {
      logic [TIMER_W-1:0] cnt;
      logic fired;
      logic done;
   } uef_tmr_type;
   uef_tmr_type st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (!cond) begin
         st_nxt.cnt = '0;
         st_nxt.fired = 1'b0;
      end else if (!st_r.fired) begin
         if (st_r.cnt == TIMER_W'(CYC - 1)) begin
            st_nxt.fired = 1'b1;
            st_nxt.done = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + TIMER_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign done = st_r.done;
endmodule

/* File: uef_pkg.sv */
// package of the usb event flag block: register map, field positions, timing
// assumes a 200 MHz pclk and a full-speed bus of 12 Mbit/s
package uef_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam logic [11:0] OFF_EVENT_FLAGS = 12'h000;
   localparam logic [11:0] OFF_EVENT_ENABLES = 12'h004;
   localparam logic [11:0] OFF_ERROR_FLAGS = 12'h008;
   localparam logic [11:0] OFF_ERROR_ENABLES = 12'h00C;
   localparam logic [11:0] OFF_XFER_STATUS = 12'h010;
   localparam int REG_BITS = 8;
   // event flag bit positions
   localparam int BIT_STALL = 7;
   localparam int BIT_ATTACH = 6;
   localparam int BIT_RESUME = 5;
   localparam int BIT_IDLE = 4;
   localparam int BIT_TOKEN_DONE = 3;
   localparam int BIT_FRAME_START = 2;
   localparam int BIT_SUMMARY_ERR = 1;
   localparam int BIT_RESET_DETACH = 0;
   // error flag bit positions
   localparam int BIT_TURNAROUND = 4;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   // line states, {dp, dm}
   localparam logic [1:0] LINE_SE0 = 2'h0;
   localparam logic [1:0] LINE_J = 2'h2;
   localparam logic [1:0] LINE_K = 2'h1;
   // timing
   localparam real HOLD_US = 2.5;
   localparam int HOLD_CYC = int'($ceil(HOLD_US * 1000.0 / CLK_PERIOD_NS));
   localparam int IDLE_MS = 3;
   localparam int IDLE_CYC = IDLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int TIMER_W = 20;
   localparam int BIT_RATE_HZ = 12000000;
   localparam int TURN_BIT_TIMES = 16;
   localparam int TURN_CYC = int'($ceil(real'(TURN_BIT_TIMES) * 1.0e9 /
      real'(BIT_RATE_HZ) / real'(CLK_PERIOD_NS)));
   localparam int TURN_W = 9;
   // transfer status fifo: endpoint[3:0], direction, ping-pong bank
   localparam int STAT_W = 6;
   localparam int STAT_DEPTH = 4;
   localparam int STAT_AW = 2;
   localparam int STAT_SHIFT = 2;
endpackage

/* File: uef_sie_model.sv */
// far-side model: serial engine event pulses and bus line levels
// assumes pclk from the bench; tasks are called by hierarchical name
module uef_sie_model
   import uef_pkg::*;
(
   input wire logic pclk, // system clock
   input wire logic token_ready, // status fifo has room
   output logic [7:0] ev, // rx/tx stall, token, sof, thr, rst, eop, pkt
   output logic [7:0] err, // error pulses by bit
   output logic [5:0] st, // token status
   output logic dp, // d+ level
   output logic dm // d- level
);
   initial begin
      ev = 8'h00;
      err = 8'h00;
      st = 6'h00;
      {dp, dm} = LINE_J;
   end

   ////////////////////////////////////////////////////////////////////////
   // one-cycle pulse; token dropped while the fifo is full
   task fire(input logic [7:0] e, input logic [7:0] r, input logic [5:0] s);
      @(posedge pclk);
      ev <= token_ready ? e : (e & 8'hDF);
      err <= r;
      st <= s;
      @(posedge pclk);
      ev <= 8'h00;
      err <= 8'h00;
      st <= ~s; // stale status never left on the bus
   endtask

   task line(input logic [1:0] s);
      @(posedge pclk);
      {dp, dm} <= s;
   endtask
endmodule

/* File: uef_stat_fifo.sv */
// transfer status fifo: small memory with registered head word
// assumes push is refused by the caller while full
module uef_stat_fifo (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic push, // store one entry
   input wire logic [uef_pkg::STAT_W-1:0] push_data, // entry stored
   input wire logic pop, // drop the head entry
   output logic [uef_pkg::STAT_W-1:0] head, // head entry, registered
   output logic [uef_pkg::STAT_AW:0] count // entries held
);
   import uef_pkg::*;
   typedef struct packed {
      logic [STAT_DEPTH-1:0][STAT_W-1:0] mem;
      logic [STAT_AW-1:0] wp;
      logic [STAT_AW-1:0] rp;
      logic [STAT_AW:0] cnt;
      logic [STAT_W-1:0] head;
   } uef_fifo_type;
   uef_fifo_type st_r, st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = push_data;
         st_nxt.wp = st_r.wp + STAT_AW'(1);
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + STAT_AW'(1);
      end
      st_nxt.cnt = st_r.cnt + (STAT_AW + 1)'(push) - (STAT_AW + 1)'(pop);
      st_nxt.head = st_nxt.mem[st_nxt.rp];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign head = st_r.head;
   assign count = st_r.cnt;
endmodule
